// >>> logic/ptc_i2c_rx.sv
// Two-wire bus byte receiver with address match and acknowledge policy
module ptc_i2c_rx (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] dev_addr,
   output logic            sda_oe,
   output logic            start_pulse,
   output logic            byte_strobe,
   output logic [1:0]      byte_index,
   output logic [7:0]      byte_data
);

   logic [2:0]             scl_sh;
   logic [2:0]             sda_sh;
   logic                   scl_reg;
   logic                   sda_reg;
   ptc_pkg::ptc_rx_state_t state_reg;
   logic [3:0]             bit_cnt_reg;
   logic [7:0]             shift_reg;
   logic                   addr_phase_reg;
   logic [2:0]             data_cnt_reg;

   // Edges count only once the second and third stages agree
   wire scl_ok    = scl_sh[1] == scl_sh[2];
   wire sda_ok    = sda_sh[1] == sda_sh[2];
   wire scl_rise  = scl_ok & scl_sh[2] & ~scl_reg;
   wire scl_fall  = scl_ok & ~scl_sh[2] & scl_reg;
   wire start_det = sda_ok & ~sda_sh[2] & sda_reg & scl_reg;
   wire stop_det  = sda_ok & sda_sh[2] & ~sda_reg & scl_reg;
   wire byte_done = scl_fall & (bit_cnt_reg == ptc_pkg::BITS_PER_BYTE);
   wire addr_hit  = shift_reg == dev_addr;
   wire data_room = data_cnt_reg < ptc_pkg::DATA_BYTES_MAX;

   assign start_pulse = start_det;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scl_sh         <= 3'h7;
         sda_sh         <= 3'h7;
         scl_reg        <= 1'b1;
         sda_reg        <= 1'b1;
         state_reg      <= ptc_pkg::ST_IDLE;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         addr_phase_reg <= 1'b1;
         data_cnt_reg   <= 3'h0;
         sda_oe         <= 1'b0;
         byte_strobe    <= 1'b0;
         byte_index     <= 2'h0;
         byte_data      <= 8'h00;
      end else begin
         scl_sh      <= {scl_sh[1:0], scl_i};
         sda_sh      <= {sda_sh[1:0], sda_i};
         scl_reg     <= scl_ok ? scl_sh[2] : scl_reg;
         sda_reg     <= sda_ok ? sda_sh[2] : sda_reg;
         byte_strobe <= 1'b0;
         if (start_det) begin
            state_reg      <= ptc_pkg::ST_SHIFT;
            bit_cnt_reg    <= 4'h0;
            addr_phase_reg <= 1'b1;
            data_cnt_reg   <= 3'h0;
            sda_oe         <= 1'b0;
         end else if (stop_det) begin
            state_reg <= ptc_pkg::ST_IDLE;
            sda_oe    <= 1'b0;
         end else begin
            unique case (state_reg)
               ptc_pkg::ST_IDLE, ptc_pkg::ST_SKIP: begin
               end
               ptc_pkg::ST_SHIFT: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_reg};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (byte_done && addr_phase_reg) begin
                     sda_oe    <= addr_hit;
                     state_reg <= addr_hit ? ptc_pkg::ST_ACK : ptc_pkg::ST_SKIP;
                  end else if (byte_done) begin
                     sda_oe      <= data_room;
                     state_reg   <= data_room ? ptc_pkg::ST_ACK : ptc_pkg::ST_SHIFT;
                     bit_cnt_reg <= 4'h0;
                  end
               end
               ptc_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     sda_oe         <= 1'b0;
                     state_reg      <= ptc_pkg::ST_SHIFT;
                     bit_cnt_reg    <= 4'h0;
                     addr_phase_reg <= 1'b0;
                     if (!addr_phase_reg) begin
                        byte_strobe  <= 1'b1;
                        byte_index   <= data_cnt_reg[1:0];
                        byte_data    <= shift_reg;
                        data_cnt_reg <= data_cnt_reg + 3'h1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // no data acknowledge past the fourth
   property p_ack_limit;
      @(posedge ref_clk) disable iff (reset)
         ($rose(sda_oe) && !addr_phase_reg) |-> (data_cnt_reg < ptc_pkg::DATA_BYTES_MAX);
   endproperty
   a_ack_limit: assert property (p_ack_limit) else $error("data byte acknowledged beyond fourth");

endmodule

// >>> logic/ptc_pkg.sv
// Shared constants and types for the tuner synthesizer control core
package ptc_pkg;

   // ----------------------------------------------------------------
   // Bus addressing and message framing
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_BASE      = 8'hC0;
   localparam logic [2:0]  DATA_BYTES_MAX = 3'h4;
   localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

   // ----------------------------------------------------------------
   // Reset values and divider ratios
   // ----------------------------------------------------------------
   localparam int          RATIO_W        = 15;
   localparam logic [14:0] RATIO_RESET    = 15'h0100;
   localparam logic [7:0]  CTRL_RESET     = 8'h82;
   localparam logic [7:0]  BAND_RESET     = 8'h00;
   localparam logic [10:0] REF_RATIO_512  = 11'h200;
   localparam logic [10:0] REF_RATIO_1024 = 11'h400;

   // ----------------------------------------------------------------
   // Byte layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic func;
      logic pump_current_bit;
      logic test_route_bit;
      logic phase_mode_bit_lo;
      logic ref_ratio_bit_b;
      logic ref_ratio_bit_a;
      logic phase_mode_bit_hi;
      logic amp_disable_bit;
   } ptc_ctrl_t;

   typedef struct packed {
      logic       band_out_7;
      logic [1:0] unused_65;
      logic       band_out_4;
      logic       unused_3;
      logic       band_out_2;
      logic       band_out_1;
      logic       band_out_0;
   } ptc_band_t;

   typedef struct packed {
      logic up_en;
      logic dn_en;
   } ptc_pump_t;

   typedef enum logic [1:0] {PM_NORMAL, PM_HIZ, PM_UP_ONLY, PM_DN_ONLY} ptc_phase_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_ACK, ST_SKIP} ptc_rx_state_t;

endpackage

// >>> logic/ptc_top.sv
// Tuner synthesizer control core: bus receiver, settings, latches, dividers
// Functional notes
// - Bus address C0, C2, C4 or C6 chosen by address select pin band.
// - Band bit one pulls its open-collector output low; zero releases it.
// - Amplifier-off bit one disables tuning amplifier output; zero runs normally.
// - Phase bits select normal, high impedance, upper only or lower only.
// - Reference ratio bits choose 512 for equal values, 1024 otherwise.
// - Test bit routes reference to band 7 and half divider to band 2.
// - Provide divider output frequency divided by two as a test signal.
// - Pump current bit selects 40 uA when zero, 125 uA when one.
// - Divider counts down and reloads ratio from second latch at zero.
// - Second latch loads from first by strobe synchronous to divider output.
// - Any bus start condition also triggers the first-to-second latch transfer.
// - Ratio is binary value of 15 frequency bits, 17 to 32767.
// - Power-on resets bus receiver and sets divider ratio to 256.
// - Band bits 0 and 4 act only on the five-output variant.
// - Leading zero marks frequency pair; leading one marks control and band.
// - With exactly three data bytes the third byte is discarded.
// - Bytes after the fourth are ignored; last acknowledge after fourth.
module ptc_top #(
   parameter bit FIVE_OUTPUTS = 1'b1
) (
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire logic         osc_div_clk,
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   output logic              sda_o,
   output logic              sda_oe,
   input  wire logic [1:0]   addr_select_pin,
   output logic [4:0]        band_pull_low,
   output logic              amp_disable,
   output ptc_pkg::ptc_phase_t phase_mode,
   output ptc_pkg::ptc_pump_t  pump_src,
   output logic              pump_high_current,
   output logic              ref_pulse,
   output logic              div_pulse
);

   // ----------------------------------------------------------------
   // Address select pin capture
   // ----------------------------------------------------------------
   logic [1:0] sel_s1;
   logic [1:0] sel_s2;
   logic [1:0] sel_s3;
   logic [1:0] sel_reg;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sel_s1  <= 2'h0;
         sel_s2  <= 2'h0;
         sel_s3  <= 2'h0;
         sel_reg <= 2'h0;
      end else begin
         sel_s1  <= addr_select_pin;
         sel_s2  <= sel_s1;
         sel_s3  <= sel_s2;
         sel_reg <= (sel_s2 == sel_s3) ? sel_s3 : sel_reg;
      end
   end

   wire [7:0] dev_addr = ptc_pkg::ADDR_BASE | {5'h00, sel_reg, 1'b0};

   // ----------------------------------------------------------------
   // Bus receiver
   // ----------------------------------------------------------------
   logic       start_pulse;
   logic       byte_strobe;
   logic [1:0] byte_index;
   logic [7:0] byte_data;

   assign sda_o = 1'b0;

   ptc_i2c_rx u_rx (
      .ref_clk     (ref_clk),
      .reset       (reset),
      .scl_i       (scl_i),
      .sda_i       (sda_i),
      .dev_addr    (dev_addr),
      .sda_oe      (sda_oe),
      .start_pulse (start_pulse),
      .byte_strobe (byte_strobe),
      .byte_index  (byte_index),
      .byte_data   (byte_data)
   );

   // ----------------------------------------------------------------
   // Byte pair assembly and settings
   // ----------------------------------------------------------------
   logic [7:0]         first_byte_reg;
   ptc_pkg::ptc_ctrl_t ctrl_reg;
   ptc_pkg::ptc_band_t band_reg;
   logic [14:0]        freq_a_reg;

   // commit only on second byte of a pair
   wire pair_end    = byte_strobe & byte_index[0];
   // leading bit selects byte pair meaning
   wire commit_freq = pair_end & ~first_byte_reg[7];
   wire commit_cb   = pair_end & first_byte_reg[7];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         first_byte_reg <= 8'h00;
         ctrl_reg       <= ptc_pkg::CTRL_RESET;
         band_reg       <= ptc_pkg::BAND_RESET;
         freq_a_reg     <= ptc_pkg::RATIO_RESET;
      end else begin
         if (byte_strobe && !byte_index[0]) begin
            first_byte_reg <= byte_data;
         end
         if (commit_cb) begin
            ctrl_reg <= ptc_pkg::ptc_ctrl_t'(first_byte_reg);
            band_reg <= ptc_pkg::ptc_band_t'(byte_data);
         end
         if (commit_freq) begin
            freq_a_reg <= {first_byte_reg[6:0], byte_data};
         end
      end
   end

   // ----------------------------------------------------------------
   // Latch transfer request toward divider domain
   // ----------------------------------------------------------------
   logic        want_reg;
   logic        req_tog_reg;
   logic [14:0] word_reg;
   logic        ack_s1;
   logic        ack_s2;
   logic        ack_tog_reg;

   // Word stays frozen while a request is outstanding, so it is safe to sample
   wire busy = req_tog_reg ^ ack_s2;
   wire send = want_reg & ~busy;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         want_reg    <= 1'b0;
         req_tog_reg <= 1'b0;
         word_reg    <= ptc_pkg::RATIO_RESET;
         ack_s1      <= 1'b0;
         ack_s2      <= 1'b0;
      end else begin
         ack_s1 <= ack_tog_reg;
         ack_s2 <= ack_s1;
         want_reg <= (want_reg & ~send) | start_pulse | commit_freq;
         if (send) begin
            word_reg    <= freq_a_reg;
            req_tog_reg <= ~req_tog_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reference divider
   // ----------------------------------------------------------------
   logic [10:0] ref_cnt_reg;
   logic        ref_wave_reg;

   wire [10:0] ref_ratio = (ctrl_reg.ref_ratio_bit_a ^ ctrl_reg.ref_ratio_bit_b) ?
                           ptc_pkg::REF_RATIO_1024 : ptc_pkg::REF_RATIO_512;
   wire        ref_tc    = ref_cnt_reg >= (ref_ratio - 11'h001);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ref_cnt_reg  <= 11'h000;
         ref_wave_reg <= 1'b0;
         ref_pulse    <= 1'b0;
      end else begin
         ref_cnt_reg  <= ref_tc ? 11'h000 : ref_cnt_reg + 11'h001;
         ref_pulse    <= ref_tc;
         ref_wave_reg <= ref_cnt_reg >= (ref_ratio >> 1);
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // amplifier disable
   assign amp_disable       = ctrl_reg.amp_disable_bit;
   assign pump_high_current = ctrl_reg.pump_current_bit;
   assign phase_mode = ctrl_reg.phase_mode_bit_hi ?
                       (ctrl_reg.phase_mode_bit_lo ? ptc_pkg::PM_HIZ : ptc_pkg::PM_NORMAL) :
                       (ctrl_reg.phase_mode_bit_lo ? ptc_pkg::PM_DN_ONLY : ptc_pkg::PM_UP_ONLY);
   assign pump_src.up_en = (phase_mode == ptc_pkg::PM_NORMAL) | (phase_mode == ptc_pkg::PM_UP_ONLY);
   assign pump_src.dn_en = (phase_mode == ptc_pkg::PM_NORMAL) | (phase_mode == ptc_pkg::PM_DN_ONLY);

   // ----------------------------------------------------------------
   // Divider domain
   // ----------------------------------------------------------------
   logic        div_rst_s1;
   logic        div_rst_reg;
   logic        req_s1;
   logic        req_s2;
   logic [14:0] latch_b_reg;
   logic [14:0] div_cnt_reg;
   logic        div_half_reg;

   wire div_tc  = div_cnt_reg == 15'h0000;
   wire pending = req_s2 ^ ack_tog_reg;

   always_ff @(posedge osc_div_clk) begin
      div_rst_s1  <= reset;
      div_rst_reg <= div_rst_s1;
   end

   always_ff @(posedge osc_div_clk) begin
      if (div_rst_reg) begin
         req_s1       <= 1'b0;
         req_s2       <= 1'b0;
         ack_tog_reg  <= 1'b0;
         latch_b_reg  <= ptc_pkg::RATIO_RESET;
         div_cnt_reg  <= ptc_pkg::RATIO_RESET - 15'h0001;
         div_half_reg <= 1'b0;
         div_pulse    <= 1'b0;
      end else begin
         req_s1    <= req_tog_reg;
         req_s2    <= req_s1;
         div_pulse <= div_tc;
         div_cnt_reg <= div_tc ? latch_b_reg - 15'h0001 : div_cnt_reg - 15'h0001;
         if (div_tc && pending) begin
            latch_b_reg <= word_reg;
            ack_tog_reg <= req_s2;
         end
         if (div_tc) begin
            div_half_reg <= ~div_half_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Band outputs
   // ----------------------------------------------------------------
   // bits 0 and 4 only on five-output part
   wire b0 = FIVE_OUTPUTS & band_reg.band_out_0;
   wire b4 = FIVE_OUTPUTS & band_reg.band_out_4;
   // test routing, relies on zero band bits
   wire b7 = band_reg.band_out_7 | (ctrl_reg.test_route_bit & ref_wave_reg);
   wire b2 = band_reg.band_out_2 | (ctrl_reg.test_route_bit & div_half_reg);
   assign band_pull_low = {b7, b4, b2, band_reg.band_out_1, b0};

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_cb_commit;
      commit_cb;
   endsequence

   sequence s_freq_commit;
      commit_freq;
   endsequence

   property p_addr_map;
      @(posedge ref_clk) disable iff (reset)
         (dev_addr[7:3] == 5'h18) && !dev_addr[0] && (dev_addr[2:1] == sel_reg);
   endproperty
   a_addr_map: assert property (p_addr_map) else $error("bus address off the map");

   property p_band_load;
      @(posedge ref_clk) disable iff (reset)
         s_cb_commit ##1 !ctrl_reg.test_route_bit |->
            band_pull_low[1] == $past(byte_data[1]) && band_pull_low[4] == $past(byte_data[7]);
   endproperty
   a_band_load: assert property (p_band_load) else $error("band output not loaded");

   property p_amp_load;
      @(posedge ref_clk) disable iff (reset)
         s_cb_commit |=> amp_disable == $past(first_byte_reg[0]);
   endproperty
   a_amp_load: assert property (p_amp_load) else $error("amplifier disable mismatch");

   property p_phase;
      @(posedge ref_clk) disable iff (reset)
         (ctrl_reg.phase_mode_bit_hi && !ctrl_reg.phase_mode_bit_lo) |-> pump_src.up_en && pump_src.dn_en;
   endproperty
   a_phase: assert property (p_phase) else $error("normal phase mode lost a source");

   property p_ref_ratio;
      @(posedge ref_clk) disable iff (reset)
         ref_pulse ##1 (ref_ratio == ptc_pkg::REF_RATIO_512)[*8] |-> !ref_pulse;
   endproperty
   a_ref_ratio: assert property (p_ref_ratio) else $error("reference pulse too early");

   property p_test_route;
      @(posedge ref_clk) disable iff (reset)
         (ctrl_reg.test_route_bit && !band_reg.band_out_7) |-> band_pull_low[4] == ref_wave_reg;
   endproperty
   a_test_route: assert property (p_test_route) else $error("reference not on band 7");

   property p_pump_load;
      @(posedge ref_clk) disable iff (reset)
         s_cb_commit |=> pump_high_current == $past(first_byte_reg[6]);
   endproperty
   a_pump_load: assert property (p_pump_load) else $error("pump current select mismatch");

   property p_start_xfer;
      @(posedge ref_clk) disable iff (reset)
         (start_pulse && !busy && !want_reg) |=> ##1 busy;
   endproperty
   a_start_xfer: assert property (p_start_xfer) else $error("start did not request transfer");

   property p_freq_pair;
      @(posedge ref_clk) disable iff (reset)
         s_freq_commit |=> freq_a_reg == {$past(first_byte_reg[6:0]), $past(byte_data)};
   endproperty
   a_freq_pair: assert property (p_freq_pair) else $error("frequency pair mis-assembled");

   property p_hold_settings;
      @(posedge ref_clk) disable iff (reset)
         !pair_end |=> $stable(ctrl_reg) && $stable(band_reg) && $stable(freq_a_reg);
   endproperty
   a_hold_settings: assert property (p_hold_settings) else $error("settings changed mid pair");

   property p_reload;
      @(posedge osc_div_clk) disable iff (div_rst_reg)
         div_tc |=> div_cnt_reg == $past(latch_b_reg) - 15'h0001;
   endproperty
   a_reload: assert property (p_reload) else $error("divider reload wrong");

   property p_latch_b;
      @(posedge osc_div_clk) disable iff (div_rst_reg)
         !div_tc |=> $stable(latch_b_reg);
   endproperty
   a_latch_b: assert property (p_latch_b) else $error("second latch moved off divider output");

endmodule

// >>> testbench/ptc_bus_master.sv
// Serial bus master model that writes messages to the control core
module ptc_bus_master #(
   parameter int Q = 16
) (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Quarter bit time; the bus runs faster than 100 kHz to keep the run short
   task automatic tick();
      repeat (Q) @(posedge ref_clk);
      #1;
   endtask
   // Start (1) or stop (0); data only moves while the clock is low elsewhere
   task automatic edge_seq(input bit is_start);
      sda_low = 1'b1;
      tick();
      scl = !is_start;
      tick();
      sda_low = is_start;
      tick();
   endtask
   // Eight data bits, then the line is released and the ninth clock samples it
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         sda_low = (i >= 0) && !b[i[2:0]];
         tick();
         scl = 1'b1;
         tick();
         ack = ~sda_line;
         tick();
         scl = 1'b0;
         tick();
      end
   endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the tuner synthesizer control core
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   int                  checks = 0;
   int                  fail_count = 0;
   int                  p;
   logic                ref_clk = 1'b0;
   logic                osc_div_clk = 1'b0;
   logic                reset = 1'b1;
   logic [1:0]          addr_sel = 2'h0;
   logic [4:0]          band_pull_low;
   logic [5:0]          ack;
   logic                scl, m_low, sda_o, sda_oe, amp_disable, pump_high_current, ref_pulse, div_pulse;
   ptc_pkg::ptc_phase_t phase_mode;
   ptc_pkg::ptc_pump_t  pump_src;
   // Open drain with pull-up: low while either party pulls
   wire                 sda = !(m_low || sda_oe);
   always #4 ref_clk = ~ref_clk;
   initial begin
      #1.7;
      forever #3 osc_div_clk = ~osc_div_clk;
   end
   ptc_top ptc_top_i (.ref_clk(ref_clk), .reset(reset), .osc_div_clk(osc_div_clk), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pin(addr_sel), .band_pull_low(band_pull_low),
      .amp_disable(amp_disable), .phase_mode(phase_mode), .pump_src(pump_src),
      .pump_high_current(pump_high_current), .ref_pulse(ref_pulse), .div_pulse(div_pulse));
   ptc_bus_master ptc_bus_master_i (.ref_clk(ref_clk), .sda_line(sda), .scl(scl), .sda_low(m_low));
   task automatic end_of_test();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic msg(input logic [47:0] d, input int n);
      logic a;
      // Pins change just after a clock edge, as every other stimulus does
      @(posedge ref_clk);
      #1;
      ack = 6'h00;
      ptc_bus_master_i.edge_seq(1'b1);
      for (int k = 0; k < n; k++) begin
         ptc_bus_master_i.put(d[47 - 8 * k -: 8], a);
         ack[k] = a;
      end
      ptc_bus_master_i.edge_seq(1'b0);
   endtask
   // Pulse period of reference (0) or divider (1); the first pulse only aligns
   task automatic per(input bit s);
      repeat (2) begin
         p = 0;
         do begin
            if (s)
               @(posedge osc_div_clk);
            else
               @(posedge ref_clk);
            #1;
            p++;
            if (p > 40000) begin
               fail_count++;
               end_of_test();
            end
         end while ((s ? div_pulse : ref_pulse) !== 1'b1);
      end
   endtask
   task automatic t_reset();
      `CHK(sda_oe, 1'b0)
      `CHK(sda_o, 1'b0)
      `CHK(band_pull_low, 5'h00)
      `CHK(amp_disable, 1'b0)
      `CHK(phase_mode, ptc_pkg::PM_NORMAL)
      per(1'b1);
      `CHK(p, 256)
   endtask
   task automatic t_addr();
      @(posedge ref_clk);
      #1;
      for (int s = 0; s < 4; s++) begin
         addr_sel = s[1:0];
         msg({8'hC0 | {5'h00, s[1:0], 1'b0}, 8'h82, 8'h00, 24'h0}, 3);
         `CHK(ack[2:0], 3'h7)
         msg({8'hC0 | {5'h00, s[1:0] + 2'h1, 1'b0}, 40'h0}, 1);
         `CHK(ack[0], 1'b0)
      end
      addr_sel = 2'h0;
   endtask
   // Phase index i: high phase bit = !i[1], low phase bit = i[0]; pump and amplifier vary with it
   task automatic t_ctrl();
      logic [3:0][7:0] bnd = {8'h03, 8'h0C, 8'h10, 8'hE0};
      logic [3:0][4:0] exp_b = {5'h03, 5'h04, 5'h08, 5'h10};
      // Sources {up, down} per phase index: both, none, up only, down only
      logic [3:0][1:0] exp_p = {2'h1, 2'h2, 2'h0, 2'h3};
      for (int i = 0; i < 4; i++) begin
         msg({8'hC0, 1'b1, i[0] ^ i[1], 1'b0, i[0], 2'h0, !i[1], i[1], bnd[i], 24'h0}, 3);
         `CHK(phase_mode, ptc_pkg::ptc_phase_t'(i[1:0]))
         `CHK(pump_src, exp_p[i])
         `CHK(pump_high_current, i[0] ^ i[1])
         `CHK(amp_disable, i[1])
         `CHK(band_pull_low, exp_b[i])
      end
      msg({8'hC0, 8'h82, 8'h02, 8'hC3, 16'h0}, 4);
      `CHK(band_pull_low, 5'h02)
      `CHK(amp_disable, 1'b0)
   endtask
   task automatic t_freq();
      // ratio 300 keeps divider output under 1 MHz at this clock
      msg({8'hC0, 8'h01, 8'h2C, 8'h82, 8'h01, 8'hA5}, 6);
      `CHK(ack, 6'h1F)
      `CHK(band_pull_low, 5'h01)
      // Old ratio may run up to two more periods before the reload
      repeat (3) per(1'b1);
      `CHK(p, 300)
   endtask
   task automatic t_ratio();
      for (int c = 0; c < 4; c++) begin
         msg({8'hC0, 4'h8, c[0], c[1], 2'h2, 8'h00, 24'h0}, 3);
         per(1'b0);
         per(1'b0);
         `CHK(p, (c == 1 || c == 2) ? 1024 : 512)
      end
   endtask
   task automatic t_test();
      logic [4:0] last;
      int         n2 = 0;
      int         n7 = 0;
      // band bits 2 and 7 written as zero
      msg({8'hC0, 8'hA2, 8'h02, 24'h0}, 3);
      last = band_pull_low;
      for (int k = 0; k < 3000; k++) begin
         @(posedge osc_div_clk);
         #1;
         n2 += int'(band_pull_low[2] != last[2]);
         n7 += int'(band_pull_low[4] != last[4]);
         last = band_pull_low;
      end
      `CHK(n2 >= 9 && n2 <= 11, 1'b1)
      `CHK(n7 >= 6, 1'b1)
      `CHK(band_pull_low[1], 1'b1)
      msg({8'hC0, 8'h82, 8'h00, 24'h0}, 3);
      `CHK(band_pull_low, 5'h00)
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      // first message only after reset has completed
      repeat (8) @(posedge ref_clk);
      #1;
      t_reset();
      t_addr();
      t_ctrl();
      t_freq();
      t_ratio();
      t_test();
      end_of_test();
   end
endmodule
